//--- design/rtc_time_value_registers.sv
// Time-value register set of the calendar clock unit with an AHB-Lite slave port.
//
// Summary of operation
// (RULE1) Year bits 7-4 hold the BCD tens digit and bits 3-0 the ones digit, each 0 to 9.
// (RULE2) A year write lands only while clock_write_enable is 1.
// (RULE3) Month-and-day bit 12 holds the month tens digit and bits 11-8 its ones digit.
// (RULE4) Month-and-day bits 5-4 hold the day tens digit (0 to 3) and bits 3-0 its ones digit.
// (RULE5) Month-and-day and weekday-and-hour writes land only while clock_write_enable is 1.
// (RULE6) Weekday-and-hour keeps the weekday code, 0 to 6, in bits 10-8.
// (RULE7) Weekday-and-hour bits 5-4 hold the hour tens digit (0 to 2) and bits 3-0 its ones digit.
// (RULE8) Minutes-and-seconds keeps the minute tens digit in bits 14-12 and the minute ones digit in bits 11-8.
// (RULE9) Minutes-and-seconds keeps the second tens digit in bits 6-4 and the second ones digit in bits 3-0.
// (RULE10) Bits outside the digit fields read as zero and ignore writes.
// (RULE11) The fields count as a BCD calendar, each field carrying into the next larger unit.
//
// Decided for this implementation: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ns
module rtc_time_value_registers (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic second_tick_pin,
    output rtc_pkg::calendar_t time_now,
    output logic clock_write_enable_out
);

    // --------
    // State and next state.
    // --------
    rtc_pkg::rtc_state_t st_reg;
    rtc_pkg::rtc_state_t st_next;

    // Filtered tick and its step.
    logic tick_level;
    logic sec_inc;

    // Carries between fields.
    logic sec_carry;
    logic min_carry;
    logic hour_carry;
    logic day_carry;
    logic month_carry;

    // Stepped digits.
    logic [2:0] sec_tens_n;
    logic [3:0] sec_ones_n;
    logic [2:0] min_tens_n;
    logic [3:0] min_ones_n;
    logic [1:0] hour_tens_n;
    logic [3:0] hour_ones_n;
    logic [1:0] day_tens_n;
    logic [3:0] day_ones_n;

    logic [1:0] day_max_tens;
    logic [3:0] day_max_ones;

    logic [0:0] month_tens_n;
    logic [3:0] month_ones_n;
    logic [3:0] year_tens_n;
    logic [3:0] year_ones_n;

    logic leap_year;

    // --------
    // Seconds tick input.
    // --------

    // The one-second tick comes in on a pin and is synchronised here.
    pin_sync u_tick_sync (
        .mclk(mclk),
        .arst_n(arst_n),
        .pin_in(second_tick_pin),
        .level_out(tick_level)
    );

    // One step per rising edge of the filtered tick, only while counting is enabled.
    assign sec_inc = tick_level & ~st_reg.tick_prev & st_reg.run;

    // --------
    // Calendar carry chain.
    // --------

    // Seconds run 00 to 59 and carry into minutes.
    bcd_field_inc #(.TW(3)) u_sec ( // see (RULE11)
        .inc(sec_inc),
        .tens_in(st_reg.cal.second_tens_digit),
        .ones_in(st_reg.cal.second_ones_digit),
        .min_tens(3'h0),
        .min_ones(rtc_pkg::RST_ZERO4),
        .max_tens(rtc_pkg::SIXTY_TENS_MAX),
        .max_ones(rtc_pkg::ONES_MAX),
        .tens_out(sec_tens_n),
        .ones_out(sec_ones_n),
        .carry(sec_carry)
    );

    // Minutes run 00 to 59 and carry into hours.
    bcd_field_inc #(.TW(3)) u_min ( // see (RULE11)
        .inc(sec_carry),
        .tens_in(st_reg.cal.minute_tens_digit),
        .ones_in(st_reg.cal.minute_ones_digit),
        .min_tens(3'h0),
        .min_ones(rtc_pkg::RST_ZERO4),
        .max_tens(rtc_pkg::SIXTY_TENS_MAX),
        .max_ones(rtc_pkg::ONES_MAX),
        .tens_out(min_tens_n),
        .ones_out(min_ones_n),
        .carry(min_carry)
    );

    // Hours run 00 to 23 and carry into the day and the weekday.
    bcd_field_inc #(.TW(2)) u_hour ( // see (RULE11)
        .inc(min_carry),
        .tens_in(st_reg.cal.hour_tens_digit),
        .ones_in(st_reg.cal.hour_ones_digit),
        .min_tens(2'h0),
        .min_ones(rtc_pkg::RST_ZERO4),
        .max_tens(rtc_pkg::HOUR_TENS_MAX),
        .max_ones(rtc_pkg::HOUR_ONES_LAST),
        .tens_out(hour_tens_n),
        .ones_out(hour_ones_n),
        .carry(hour_carry)
    );

    // --------
    // Month length.
    // --------

    // A year is a leap year when its two BCD digits form a multiple of four.
    always_comb begin
        if (st_reg.cal.year_tens_digit[0] == 1'b0) begin
            leap_year = (st_reg.cal.year_ones_digit == 4'h0) || (st_reg.cal.year_ones_digit == 4'h4)
                || (st_reg.cal.year_ones_digit == 4'h8);
        end else begin
            leap_year = (st_reg.cal.year_ones_digit == 4'h2) || (st_reg.cal.year_ones_digit == 4'h6);
        end
    end

    // Last day of the current month: 28 or 29 in February, 30 in the short months, else 31.
    always_comb begin
        day_max_tens = 2'h3;
        day_max_ones = 4'h1;
        if (st_reg.cal.month_tens_digit == 1'b0 && st_reg.cal.month_ones_digit == 4'h2) begin
            day_max_tens = 2'h2;
            day_max_ones = leap_year ? 4'h9 : 4'h8;
        end else if (st_reg.cal.month_tens_digit == 1'b0 && (st_reg.cal.month_ones_digit == 4'h4
                || st_reg.cal.month_ones_digit == 4'h6 || st_reg.cal.month_ones_digit == 4'h9)) begin
            day_max_ones = 4'h0;
        end else if (st_reg.cal.month_tens_digit == 1'b1 && st_reg.cal.month_ones_digit == 4'h1) begin
            day_max_ones = 4'h0;
        end
    end

    // Days run 01 to the month's last day and carry into months.
    bcd_field_inc #(.TW(2)) u_day ( // see (RULE11)
        .inc(hour_carry),
        .tens_in(st_reg.cal.day_tens_digit),
        .ones_in(st_reg.cal.day_ones_digit),
        .min_tens(2'h0),
        .min_ones(rtc_pkg::RST_ONE4),
        .max_tens(day_max_tens),
        .max_ones(day_max_ones),
        .tens_out(day_tens_n),
        .ones_out(day_ones_n),
        .carry(day_carry)
    );

    // Months run 01 to 12 and carry into years.
    bcd_field_inc #(.TW(1)) u_month ( // see (RULE11)
        .inc(day_carry),
        .tens_in(st_reg.cal.month_tens_digit),
        .ones_in(st_reg.cal.month_ones_digit),
        .min_tens(1'b0),
        .min_ones(rtc_pkg::RST_ONE4),
        .max_tens(rtc_pkg::MONTH_TENS_LAST),
        .max_ones(rtc_pkg::MONTH_ONES_LAST),
        .tens_out(month_tens_n),
        .ones_out(month_ones_n),
        .carry(month_carry)
    );

    // Years run 00 to 99 and wrap.
    bcd_field_inc #(.TW(4)) u_year ( // see (RULE11)
        .inc(month_carry),
        .tens_in(st_reg.cal.year_tens_digit),
        .ones_in(st_reg.cal.year_ones_digit),
        .min_tens(rtc_pkg::RST_ZERO4),
        .min_ones(rtc_pkg::RST_ZERO4),
        .max_tens(rtc_pkg::YEAR_TENS_MAX),
        .max_ones(rtc_pkg::ONES_MAX),
        .tens_out(year_tens_n),
        .ones_out(year_ones_n),
        .carry()
    );

    // --------
    // Read word assembly.
    // --------

    // Builds the read word; every bit outside a digit field or a control bit stays zero.
    function automatic logic [31:0] read_word(input logic [7:0] ofs, input rtc_pkg::rtc_state_t s);
        logic [31:0] w;
        w = 32'h0000_0000; // see (RULE10)
        if (ofs == rtc_pkg::OFS_YEAR) begin
            w[rtc_pkg::YEAR_TENS_LSB +: 4] = s.cal.year_tens_digit; // see (RULE1)
            w[rtc_pkg::YEAR_ONES_LSB +: 4] = s.cal.year_ones_digit;
        end else if (ofs == rtc_pkg::OFS_MONTH_DAY) begin
            w[rtc_pkg::MONTH_TENS_LSB] = s.cal.month_tens_digit; // see (RULE3)
            w[rtc_pkg::MONTH_ONES_LSB +: 4] = s.cal.month_ones_digit;
            w[rtc_pkg::DAY_TENS_LSB +: 2] = s.cal.day_tens_digit; // see (RULE4)
            w[rtc_pkg::DAY_ONES_LSB +: 4] = s.cal.day_ones_digit;
        end else if (ofs == rtc_pkg::OFS_WEEKDAY_HOUR) begin
            w[rtc_pkg::WEEKDAY_LSB +: 3] = s.cal.weekday_code; // see (RULE6)
            w[rtc_pkg::HOUR_TENS_LSB +: 2] = s.cal.hour_tens_digit; // see (RULE7)
            w[rtc_pkg::HOUR_ONES_LSB +: 4] = s.cal.hour_ones_digit;
        end else if (ofs == rtc_pkg::OFS_MINUTE_SECOND) begin
            w[rtc_pkg::MINUTE_TENS_LSB +: 3] = s.cal.minute_tens_digit; // see (RULE8)
            w[rtc_pkg::MINUTE_ONES_LSB +: 4] = s.cal.minute_ones_digit;
            w[rtc_pkg::SECOND_TENS_LSB +: 3] = s.cal.second_tens_digit; // see (RULE9)
            w[rtc_pkg::SECOND_ONES_LSB +: 4] = s.cal.second_ones_digit;
        end else if (ofs == rtc_pkg::OFS_CONTROL) begin
            w[rtc_pkg::CTRL_WREN_BIT] = s.clock_write_enable;
            w[rtc_pkg::CTRL_RUN_BIT] = s.run;
            w[rtc_pkg::CTRL_TICK_BIT] = s.tick_prev;
        end

        return w;
    endfunction

    // --------
    // Next-state logic.
    // --------

    // Apply the calendar step, then any write in its data phase, then capture a new address phase.
    always_comb begin
        st_next = st_reg;
        st_next.tick_prev = tick_level;

        // Take the stepped digits from the carry chain.
        st_next.cal.second_tens_digit = sec_tens_n;
        st_next.cal.second_ones_digit = sec_ones_n;
        st_next.cal.minute_tens_digit = min_tens_n;
        st_next.cal.minute_ones_digit = min_ones_n;
        st_next.cal.hour_tens_digit = hour_tens_n;
        st_next.cal.hour_ones_digit = hour_ones_n;
        st_next.cal.day_tens_digit = day_tens_n;
        st_next.cal.day_ones_digit = day_ones_n;
        st_next.cal.month_tens_digit = month_tens_n[0];
        st_next.cal.month_ones_digit = month_ones_n;
        st_next.cal.year_tens_digit = year_tens_n;
        st_next.cal.year_ones_digit = year_ones_n;

        // Weekday steps with each new day and wraps from 6 to 0.
        if (hour_carry) begin
            if (st_reg.cal.weekday_code >= rtc_pkg::WEEKDAY_MAX) begin // see (RULE11)
                st_next.cal.weekday_code = 3'h0;
            end else begin
                st_next.cal.weekday_code = st_reg.cal.weekday_code + 3'h1;
            end
        end

        // A software write overrides the step for the register it targets.
        if (st_reg.dphase_wr) begin
            if (st_reg.dphase_addr == rtc_pkg::OFS_YEAR) begin
                if (st_reg.clock_write_enable) begin // see (RULE2)
                    st_next.cal.year_tens_digit = hwdata[rtc_pkg::YEAR_TENS_LSB +: 4]; // see (RULE1)
                    st_next.cal.year_ones_digit = hwdata[rtc_pkg::YEAR_ONES_LSB +: 4];
                end
            end else if (st_reg.dphase_addr == rtc_pkg::OFS_MONTH_DAY) begin
                if (st_reg.clock_write_enable) begin // see (RULE5)
                    st_next.cal.month_tens_digit = hwdata[rtc_pkg::MONTH_TENS_LSB]; // see (RULE3)
                    st_next.cal.month_ones_digit = hwdata[rtc_pkg::MONTH_ONES_LSB +: 4];
                    st_next.cal.day_tens_digit = hwdata[rtc_pkg::DAY_TENS_LSB +: 2]; // see (RULE4)
                    st_next.cal.day_ones_digit = hwdata[rtc_pkg::DAY_ONES_LSB +: 4];
                end
            end else if (st_reg.dphase_addr == rtc_pkg::OFS_WEEKDAY_HOUR) begin
                if (st_reg.clock_write_enable) begin // see (RULE5)
                    st_next.cal.weekday_code = hwdata[rtc_pkg::WEEKDAY_LSB +: 3]; // see (RULE6)
                    st_next.cal.hour_tens_digit = hwdata[rtc_pkg::HOUR_TENS_LSB +: 2]; // see (RULE7)
                    st_next.cal.hour_ones_digit = hwdata[rtc_pkg::HOUR_ONES_LSB +: 4];
                end
            end else if (st_reg.dphase_addr == rtc_pkg::OFS_MINUTE_SECOND) begin
                st_next.cal.minute_tens_digit = hwdata[rtc_pkg::MINUTE_TENS_LSB +: 3]; // see (RULE8)
                st_next.cal.minute_ones_digit = hwdata[rtc_pkg::MINUTE_ONES_LSB +: 4];
                st_next.cal.second_tens_digit = hwdata[rtc_pkg::SECOND_TENS_LSB +: 3]; // see (RULE9)
                st_next.cal.second_ones_digit = hwdata[rtc_pkg::SECOND_ONES_LSB +: 4];
            end else if (st_reg.dphase_addr == rtc_pkg::OFS_CONTROL) begin
                st_next.clock_write_enable = hwdata[rtc_pkg::CTRL_WREN_BIT];
                st_next.run = hwdata[rtc_pkg::CTRL_RUN_BIT];
            end
        end

        // Address phase: a read is answered from the value that stands during its data phase.
        st_next.dphase_wr = 1'b0;
        if (hsel && hready && htrans[1]) begin
            st_next.dphase_addr = haddr[7:0];
            st_next.dphase_wr = hwrite;
            if (!hwrite) begin
                st_next.rdata = read_word(haddr[7:0], st_next); // see (RULE10)
            end
        end

        // No wait states and an OKAY answer on every transfer.
        st_next.readyout = 1'b1;
        st_next.resp = 1'b0;
    end

    // --------
    // State register.
    // --------

    // Reset to midnight of day 01, month 01, year 00, with year, month-and-day and weekday-and-hour writes locked.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
            st_reg.cal.day_ones_digit <= rtc_pkg::RST_ONE4;
            st_reg.cal.month_ones_digit <= rtc_pkg::RST_ONE4;
            st_reg.clock_write_enable <= rtc_pkg::RST_WREN;
            st_reg.run <= rtc_pkg::RST_RUN;
            st_reg.readyout <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // --------
    // Outputs.
    // --------

    // Outputs straight from the state register.
    assign hreadyout = st_reg.readyout;
    assign hrdata = st_reg.rdata;
    assign hresp = st_reg.resp;
    assign time_now = st_reg.cal;
    assign clock_write_enable_out = st_reg.clock_write_enable;

endmodule

//--- design/rtc_pkg.sv
// Shared constants and types for the calendar time-value register block.
package rtc_pkg;

    // --------
    // Register byte offsets on the AHB-Lite port.
    // --------
    localparam logic [7:0] OFS_YEAR = 8'h00;
    localparam logic [7:0] OFS_MONTH_DAY = 8'h04;
    localparam logic [7:0] OFS_WEEKDAY_HOUR = 8'h08;
    localparam logic [7:0] OFS_MINUTE_SECOND = 8'h0C;
    localparam logic [7:0] OFS_CONTROL = 8'h10;

    // --------
    // Field positions (least significant bit of each field).
    // --------
    localparam int YEAR_TENS_LSB = 4;
    localparam int YEAR_ONES_LSB = 0;
    localparam int MONTH_TENS_LSB = 12;
    localparam int MONTH_ONES_LSB = 8;
    localparam int DAY_TENS_LSB = 4;
    localparam int DAY_ONES_LSB = 0;
    localparam int WEEKDAY_LSB = 8;
    localparam int HOUR_TENS_LSB = 4;
    localparam int HOUR_ONES_LSB = 0;
    localparam int MINUTE_TENS_LSB = 12;
    localparam int MINUTE_ONES_LSB = 8;
    localparam int SECOND_TENS_LSB = 4;
    localparam int SECOND_ONES_LSB = 0;
    localparam int CTRL_WREN_BIT = 0;
    localparam int CTRL_RUN_BIT = 1;
    localparam int CTRL_TICK_BIT = 2;

    // --------
    // Reset values: midnight, day 01 of month 01, year 00, weekday 0.
    // --------
    localparam logic [3:0] RST_ZERO4 = 4'h0;
    localparam logic [3:0] RST_ONE4 = 4'h1;
    localparam logic RST_WREN = 1'b0;
    localparam logic RST_RUN = 1'b1;

    // --------
    // Digit limits of the calendar counter.
    // --------
    localparam logic [3:0] ONES_MAX = 4'h9;
    localparam logic [2:0] SIXTY_TENS_MAX = 3'h5;
    localparam logic [1:0] HOUR_TENS_MAX = 2'h2;
    localparam logic [3:0] HOUR_ONES_LAST = 4'h3;
    localparam logic [2:0] WEEKDAY_MAX = 3'h6;
    localparam logic MONTH_TENS_LAST = 1'b1;
    localparam logic [3:0] MONTH_ONES_LAST = 4'h2;
    localparam logic [3:0] YEAR_TENS_MAX = 4'h9;

    // Calendar digits as held by the four time-value registers.
    typedef struct packed {
        logic [3:0] year_tens_digit;
        logic [3:0] year_ones_digit;
        logic month_tens_digit;
        logic [3:0] month_ones_digit;
        logic [1:0] day_tens_digit;
        logic [3:0] day_ones_digit;
        logic [2:0] weekday_code;
        logic [1:0] hour_tens_digit;
        logic [3:0] hour_ones_digit;
        logic [2:0] minute_tens_digit;
        logic [3:0] minute_ones_digit;
        logic [2:0] second_tens_digit;
        logic [3:0] second_ones_digit;
    } calendar_t;

    // Whole state of the register block.
    typedef struct packed {
        calendar_t cal;
        logic clock_write_enable;
        logic run;
        logic tick_prev;
        logic dphase_wr;
        logic [7:0] dphase_addr;
        logic [31:0] rdata;
        logic readyout;
        logic resp;
    } rtc_state_t;

    // State of the three-stage pin synchroniser.
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } sync_state_t;

endpackage

//--- design/pin_sync.sv
// Three-stage synchroniser with agreement filter for one pin input.
`timescale 1ns/1ns
module pin_sync (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic pin_in,
    output logic level_out
);

    rtc_pkg::sync_state_t st_reg;
    rtc_pkg::sync_state_t st_next;

    // Shift the pin in; the level moves only once stages two and three agree.
    always_comb begin
        st_next = st_reg;
        st_next.s1 = pin_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        if (st_reg.s2 == st_reg.s3) begin
            st_next.level = st_reg.s3;
        end
    end

    // Register the synchroniser state.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level_out = st_reg.level;

endmodule

//--- design/bcd_field_inc.sv
// Combinational two-digit BCD field stepper with wrap and carry.
`timescale 1ns/1ns
module bcd_field_inc #(
    parameter int TW = 3
) (
    input wire logic inc,
    input wire logic [TW-1:0] tens_in,
    input wire logic [3:0] ones_in,
    input wire logic [TW-1:0] min_tens,
    input wire logic [3:0] min_ones,
    input wire logic [TW-1:0] max_tens,
    input wire logic [3:0] max_ones,
    output logic [TW-1:0] tens_out,
    output logic [3:0] ones_out,
    output logic carry
);

    // Ones digit rolls into tens; the whole field wraps to its minimum at its maximum.
    always_comb begin
        tens_out = tens_in;
        ones_out = ones_in;
        carry = 1'b0;
        if (inc) begin
            if (tens_in == max_tens && ones_in == max_ones) begin
                tens_out = min_tens;
                ones_out = min_ones;
                carry = 1'b1;
            end else if (ones_in >= rtc_pkg::ONES_MAX) begin
                tens_out = tens_in + TW'(1);
                ones_out = 4'h0;
            end else begin
                ones_out = ones_in + 4'h1;
            end
        end
    end

endmodule

//--- verification/rtc_time_value_registers_monitor.sv
// Port-level checker for the calendar time-value register block.
`timescale 1ns/1ns
module rtc_time_value_registers_monitor (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic second_tick_pin,
    input wire rtc_pkg::calendar_t time_now,
    input wire logic clock_write_enable_out
);
    // --------
    // Data phase tracking.
    // --------
    logic dp_rd;
    logic dp_wr;
    logic [7:0] dp_a;
    // Kind and offset of the transfer now in its data phase.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            dp_rd <= 1'b0;
            dp_wr <= 1'b0;
            dp_a <= 8'h00;
        end else begin
            dp_rd <= hsel & hready & htrans[1] & ~hwrite;
            dp_wr <= hsel & hready & htrans[1] & hwrite;
            dp_a <= haddr[7:0];
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // --------
    // Properties.
    // --------
    property p_okay; hreadyout && !hresp; endproperty
    property p_upper; dp_rd |-> hrdata[31:16] == 16'h0000; endproperty
    property p_year_rd; dp_rd && dp_a == rtc_pkg::OFS_YEAR |->
        hrdata[15:0] == {8'h00, time_now[41:34]}; endproperty
    property p_md_rd; dp_rd && dp_a == rtc_pkg::OFS_MONTH_DAY |-> hrdata[15:0] == {3'h0, time_now.month_tens_digit,
        time_now.month_ones_digit, 2'h0, time_now.day_tens_digit, time_now.day_ones_digit}; endproperty
    property p_wh_rd; dp_rd && dp_a == rtc_pkg::OFS_WEEKDAY_HOUR |-> hrdata[15:0] == {5'h00, time_now.weekday_code,
        2'h0, time_now.hour_tens_digit, time_now.hour_ones_digit}; endproperty
    property p_ms_rd; dp_rd && dp_a == rtc_pkg::OFS_MINUTE_SECOND |-> hrdata[15:0] == {1'b0, time_now.minute_tens_digit,
        time_now.minute_ones_digit, 1'b0, time_now.second_tens_digit, time_now.second_ones_digit}; endproperty
    property p_year_gate; dp_wr && dp_a == rtc_pkg::OFS_YEAR && !clock_write_enable_out |=>
        $stable(time_now[41:34]); endproperty
    property p_year_wr; dp_wr && dp_a == rtc_pkg::OFS_YEAR && clock_write_enable_out |=>
        time_now[41:34] == $past(hwdata[7:0]); endproperty
    property p_md_gate; dp_wr && (dp_a == rtc_pkg::OFS_MONTH_DAY || dp_a == rtc_pkg::OFS_WEEKDAY_HOUR)
        && !clock_write_enable_out |=> $stable(time_now[33:14]); endproperty
    property p_ms_wr; dp_wr && dp_a == rtc_pkg::OFS_MINUTE_SECOND |=>
        time_now[13:0] == {$past(hwdata[14:8]), $past(hwdata[6:0])}; endproperty
    a_okay: assert property (p_okay) else $error("Bus answer not ready or not okay.");
    a_upper: assert property (p_upper) else $error("Upper read half not zero.");
    a_year_rd: assert property (p_year_rd) else $error("Year read wrong.");
    a_md_rd: assert property (p_md_rd) else $error("Month and day read wrong.");
    a_wh_rd: assert property (p_wh_rd) else $error("Weekday and hour read wrong.");
    a_ms_rd: assert property (p_ms_rd) else $error("Minute and second read wrong.");
    a_year_gate: assert property (p_year_gate) else $error("Year changed by gated write.");
    a_year_wr: assert property (p_year_wr) else $error("Year write lost.");
    a_md_gate: assert property (p_md_gate) else $error("Calendar changed by gated write.");
    a_ms_wr: assert property (p_ms_wr) else $error("Minute and second write lost.");
    c_year_wr: cover property (p_year_wr);
    c_gate: cover property (dp_wr && !clock_write_enable_out);
    c_ms_rd: cover property (dp_rd && dp_a == rtc_pkg::OFS_MINUTE_SECOND);
endmodule

bind rtc_time_value_registers rtc_time_value_registers_monitor rtc_time_value_registers_monitor_i (
    .mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .second_tick_pin(second_tick_pin), .time_now(time_now), .clock_write_enable_out(clock_write_enable_out));

//--- verification/rtc_time_value_registers_test.sv
// Self-checking testbench for the calendar time-value register block.
`timescale 1ns/1ns
module rtc_time_value_registers_test;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    logic second_tick_pin = 1'b0;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    rtc_pkg::calendar_t time_now;
    logic clock_write_enable_out;
    int failures = 0;
    int checks_done = 0;

    // Clock of 10 ns period.
    always #5 mclk = ~mclk;

    rtc_time_value_registers rtc_time_value_registers_i (.mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .second_tick_pin(second_tick_pin),
        .time_now(time_now), .clock_write_enable_out(clock_write_enable_out));

    // --------
    // Shared tasks.
    // --------
    // Prints the counts and the verdict, then stops.
    task automatic conclude();
        $display("Mismatches %0d, checks %0d", failures, checks_done);
        if (failures == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Compares one value and counts it.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One AHB-Lite word transfer, each phase bounded.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        n = 0;
        do begin @(posedge mclk); n++; end while (hreadyout !== 1'b1 && n < 20);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin @(posedge mclk); n++; end while (hreadyout !== 1'b1 && n < 40);
        rd = hrdata;
        if (n >= 20) begin
            $display("MISMATCH at %0t: bus timeout", $time);
            failures++;
            conclude();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h00000000, r);
        check(r, e);
    endtask

    // One pulse on the tick pin, then time to pass the synchroniser.
    task automatic tick();
        second_tick_pin <= 1'b1;
        repeat (5) @(posedge mclk);
        second_tick_pin <= 1'b0;
        repeat (10) @(posedge mclk);
    endtask

    // --------
    // Scenarios.
    // --------
    // Writes with the enable clear are dropped, except minutes and seconds.
    task automatic t_gate();
        wr(rtc_pkg::OFS_YEAR, 32'hFFFF0042);
        wr(rtc_pkg::OFS_MONTH_DAY, 32'h00000512);
        wr(rtc_pkg::OFS_WEEKDAY_HOUR, 32'h00000313);
        wr(rtc_pkg::OFS_MINUTE_SECOND, 32'h00001234);
        rd_chk(rtc_pkg::OFS_YEAR, 32'h00000000);
        rd_chk(rtc_pkg::OFS_MONTH_DAY, 32'h00000101);
        rd_chk(rtc_pkg::OFS_WEEKDAY_HOUR, 32'h00000000);
        rd_chk(rtc_pkg::OFS_MINUTE_SECOND, 32'h00001234);
    endtask

    // All ones written: only the digit fields keep them; unmapped space reads zero.
    task automatic t_fields();
        wr(rtc_pkg::OFS_CONTROL, 32'h00000003);
        wr(rtc_pkg::OFS_YEAR, 32'hFFFFFFFF);
        wr(rtc_pkg::OFS_MONTH_DAY, 32'hFFFFFFFF);
        wr(rtc_pkg::OFS_WEEKDAY_HOUR, 32'hFFFFFFFF);
        wr(rtc_pkg::OFS_MINUTE_SECOND, 32'hFFFFFFFF);
        wr(8'h20, 32'hFFFFFFFF);
        rd_chk(rtc_pkg::OFS_YEAR, 32'h000000FF);
        rd_chk(rtc_pkg::OFS_MONTH_DAY, 32'h00001F3F);
        rd_chk(rtc_pkg::OFS_WEEKDAY_HOUR, 32'h0000073F);
        rd_chk(rtc_pkg::OFS_MINUTE_SECOND, 32'h00007F7F);
        rd_chk(8'h20, 32'h00000000);
        wr(rtc_pkg::OFS_YEAR, 32'h00000059);
        @(posedge mclk);
        check({24'h000000, time_now[41:34]}, 32'h00000059);
    endtask

    // Last second of the century carries through every field; run clear stops counting.
    task automatic t_roll();
        wr(rtc_pkg::OFS_YEAR, 32'h00000099);
        wr(rtc_pkg::OFS_MONTH_DAY, 32'h00001231);
        wr(rtc_pkg::OFS_WEEKDAY_HOUR, 32'h00000623);
        wr(rtc_pkg::OFS_MINUTE_SECOND, 32'h00005959);
        tick();
        rd_chk(rtc_pkg::OFS_YEAR, 32'h00000000);
        rd_chk(rtc_pkg::OFS_MONTH_DAY, 32'h00000101);
        rd_chk(rtc_pkg::OFS_WEEKDAY_HOUR, 32'h00000000);
        rd_chk(rtc_pkg::OFS_MINUTE_SECOND, 32'h00000000);
        tick();
        rd_chk(rtc_pkg::OFS_MINUTE_SECOND, 32'h00000001);
        wr(rtc_pkg::OFS_CONTROL, 32'h00000001);
        tick();
        rd_chk(rtc_pkg::OFS_MINUTE_SECOND, 32'h00000001);
    endtask

    // Reset for five cycles, then the scenarios.
    initial begin
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        t_gate();
        t_fields();
        t_roll();
        conclude();
    end
endmodule
